// >>> hw/fct_pkg.sv
package fct_pkg;
    // Divider register width and reset value.
    localparam int DIV_W = 7;
    localparam logic [6:0] DIV_RST = 7'h00;
    // Timing clock band limits in kHz.
    localparam int FLASH_TIMING_CLOCK_MIN_KHZ = 150;
    localparam int FLASH_TIMING_CLOCK_MAX_KHZ = 200;
    // Command durations in timing clock cycles.
    localparam int BYTE_PROG_CYC = 9;
    localparam int BURST_PROG_CYC = 4;
    localparam int PAGE_ERASE_CYC = 4000;
    localparam int MASS_ERASE_CYC = 20000;
    // Array organisation.
    localparam int PAGE_BYTES = 512;
    localparam int PAGE_COUNT = 64;
    localparam int ROW_BYTES = 64;
    localparam int ADDR_W = 15;
    localparam int CNT_W = 15;
    // Command codes.
    typedef enum logic [1:0]
    {
        FCT_CMD_BYTE = 2'h0,
        FCT_CMD_BURST = 2'h1,
        FCT_CMD_PAGE = 2'h2,
        FCT_CMD_MASS = 2'h3
    } fct_cmd_t;
    // Sequencer states, Gray coded along idle, run, done.
    typedef enum logic [1:0]
    {
        FCT_IDLE = 2'h0,
        FCT_RUN = 2'h1,
        FCT_DONE = 2'h3
    } fct_state_t;
endpackage

// >>> hw/fct_flash_command_timing.sv
// What this block does
// - No program or erase is accepted until the divider has been written.
// - Only the first divider write after reset made with the error flag clear takes effect.
// - Divider writes are ignored while the access error flag is set.
// - Timing clock is the bus clock divided per the divider value.
// - Every pulse is a whole count of timing clock periods; here the prescaler runs free, so the first period of a pulse can be partial.
// - Byte program 9, page erase 4000, mass erase 20000 cycles.
// - Burst byte program takes 4 cycles, excluding start and end overhead.
// - Array is 64 pages of 512 bytes; page erase clears one page.
// - Pump stays on across bursts only if queued and same 64-byte row.
`timescale 1ns/1ps
module fct_flash_command_timing
    import fct_pkg::*;
#(
    parameter int PAGE_CYC = PAGE_ERASE_CYC,
    parameter int MASS_CYC = MASS_ERASE_CYC
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Divider write port.
    input wire logic div_wr,
    input wire logic [fct_pkg::DIV_W-1:0] div_wdata,
    // Command request.
    input wire logic cmd_valid,
    input wire fct_pkg::fct_cmd_t cmd_code,
    input wire logic [fct_pkg::ADDR_W-1:0] cmd_addr,
    output logic cmd_ready,
    // Error flag clear, write one.
    input wire logic err_clear,
    // Status.
    output logic [fct_pkg::DIV_W-1:0] flash_clock_divider,
    output logic div_loaded,
    output logic access_error_flag,
    output logic busy,
    output logic cmd_done,
    output logic pump_on,
    output logic flash_timing_clock,
    output logic [5:0] erase_page
);
    import fct_pkg::*;

    logic [DIV_W-1:0] div_ff, nxt_div;
    logic loaded_ff, err_ff, done_ff, pump_ff;
    logic [DIV_W-1:0] pre_ff;
    logic tick_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [5:0] page_ff;
    fct_cmd_t code_ff;
    fct_state_t state_ff, nxt_state;

    // Duration of a command in timing clock cycles.
    function automatic logic [CNT_W-1:0] dur(input fct_cmd_t c);
        case (c)
            FCT_CMD_BYTE: dur = CNT_W'(BYTE_PROG_CYC);
            FCT_CMD_BURST: dur = CNT_W'(BURST_PROG_CYC);
            FCT_CMD_PAGE: dur = CNT_W'(PAGE_CYC);
            default: dur = CNT_W'(MASS_CYC);
        endcase
    endfunction

    // Divider write is taken once, and never while the error flag is up.
    wire div_take = div_wr && !loaded_ff && !err_ff;
    assign nxt_div = div_take ? div_wdata : div_ff;
    wire idle_st = (state_ff == FCT_IDLE) || (state_ff == FCT_DONE);
    wire cmd_take = cmd_valid && idle_st && loaded_ff;
    wire cmd_rej = cmd_valid && !loaded_ff;
    wire last = tick_ff && (cnt_ff == CNT_W'(1)) && (state_ff == FCT_RUN);
    // A queued burst to the same row keeps the pump on, but only when the
    // command now ending is itself a burst; any other command drops it.
    wire same_row = cmd_addr[ADDR_W-1:6] == addr_ff[ADDR_W-1:6];
    wire keep_pump = cmd_valid && cmd_code == FCT_CMD_BURST &&
        code_ff == FCT_CMD_BURST && same_row && pump_ff;
    // The page field picks one 512-byte page out of 64.
    wire [5:0] page_of = cmd_addr[14:9];

    assign cmd_ready = idle_st || !loaded_ff;

    // Divider and sticky flags; the reject event wins over the clear.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            div_ff <= DIV_RST;
            loaded_ff <= 1'b0;
            err_ff <= 1'b0;
        end
        else
        begin
            div_ff <= nxt_div;
            loaded_ff <= loaded_ff | div_take;
            err_ff <= cmd_rej | (err_ff & ~err_clear);
        end
    end

    // Prescaler; one tick per (div+1) bus clocks forms the timing clock.
    always_ff @(posedge clk)
    begin
        if (reset || !loaded_ff)
        begin
            pre_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            pre_ff <= (pre_ff == div_ff) ? '0 : pre_ff + 1'b1;
            tick_ff <= (pre_ff == div_ff);
        end
    end

    // Sequencer next state.
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            FCT_IDLE: if (cmd_take) nxt_state = FCT_RUN;
            FCT_RUN: if (last) nxt_state = FCT_DONE;
            FCT_DONE: nxt_state = cmd_take ? FCT_RUN : FCT_IDLE;
            default: nxt_state = FCT_IDLE;
        endcase
    end

    // Pulse counter counts down timing clock ticks from the free-running prescaler.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_ff <= FCT_IDLE;
            cnt_ff <= '0;
            addr_ff <= '0;
            page_ff <= '0;
            code_ff <= FCT_CMD_BYTE;
            done_ff <= 1'b0;
            pump_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            done_ff <= last;
            if (cmd_take)
            begin
                cnt_ff <= dur(cmd_code);
                addr_ff <= cmd_addr;
                code_ff <= cmd_code;
                if (cmd_code == FCT_CMD_PAGE)
                    page_ff <= page_of;
                pump_ff <= 1'b1;
            end
            else if (state_ff == FCT_RUN && tick_ff)
                cnt_ff <= cnt_ff - 1'b1;
            if (last && !keep_pump)
                pump_ff <= 1'b0;
            else if (state_ff == FCT_DONE && !cmd_take)
                pump_ff <= 1'b0;
        end
    end

    assign flash_clock_divider = div_ff;
    assign div_loaded = loaded_ff;
    assign access_error_flag = err_ff;
    assign busy = state_ff == FCT_RUN;
    assign cmd_done = done_ff;
    assign pump_on = pump_ff;
    assign flash_timing_clock = tick_ff;
    assign erase_page = page_ff;

    // Assertion helpers: bus clocks since the last tick, and the ticks that
    // the running command has used. Counters keep long spans cheap to check.
    logic [DIV_W-1:0] gap_ff;
    logic seen_tick_ff;
    logic [CNT_W-1:0] run_tick_ff;

    // Helper counters only observe; they drive no output.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            gap_ff <= '0;
            seen_tick_ff <= 1'b0;
            run_tick_ff <= '0;
        end
        else
        begin
            gap_ff <= tick_ff ? '0 : gap_ff + 1'b1;
            seen_tick_ff <= seen_tick_ff | tick_ff;
            if (cmd_take)
                run_tick_ff <= '0;
            else if (busy && tick_ff)
                run_tick_ff <= run_tick_ff + 1'b1;
        end
    end

    // Second divider write must not change the stored value.
    AST_DIV_ONCE: assert property (@(posedge clk)
        disable iff (reset) loaded_ff && div_wr |=> $stable(div_ff))
        else $error("divider changed after first write");
    AST_DIV_ERR: assert property (@(posedge clk)
        disable iff (reset) err_ff && div_wr && !loaded_ff |=> !loaded_ff)
        else $error("divider loaded while error set");
    AST_NO_EARLY: assert property (@(posedge clk)
        disable iff (reset) !loaded_ff |-> state_ff != FCT_RUN)
        else $error("command ran before divider write");
    AST_REJ: assert property (@(posedge clk)
        disable iff (reset) cmd_valid && !loaded_ff |=> err_ff)
        else $error("early command did not set error");
    // A tick comes exactly when div+1 bus clocks have passed since the last.
    AST_TICK: assert property (@(posedge clk)
        disable iff (reset) seen_tick_ff |-> tick_ff == (gap_ff == div_ff))
        else $error("tick spacing wrong");
    // Each command ends after its own number of timing clock periods.
    AST_BYTE: assert property (@(posedge clk)
        disable iff (reset) cmd_done && code_ff == FCT_CMD_BYTE
        |-> run_tick_ff == CNT_W'(BYTE_PROG_CYC))
        else $error("byte program length wrong");
    AST_BURST: assert property (@(posedge clk)
        disable iff (reset) cmd_done && code_ff == FCT_CMD_BURST
        |-> run_tick_ff == CNT_W'(BURST_PROG_CYC))
        else $error("burst length wrong");
    AST_PAGE_LEN: assert property (@(posedge clk)
        disable iff (reset) cmd_done && code_ff == FCT_CMD_PAGE
        |-> run_tick_ff == CNT_W'(PAGE_CYC))
        else $error("page erase length wrong");
    AST_MASS_LEN: assert property (@(posedge clk)
        disable iff (reset) cmd_done && code_ff == FCT_CMD_MASS
        |-> run_tick_ff == CNT_W'(MASS_CYC))
        else $error("mass erase length wrong");
    // Outside a burst chain the pump drops as the command ends.
    AST_PUMP: assert property (@(posedge clk)
        disable iff (reset) last && code_ff != FCT_CMD_BURST |=> !pump_ff)
        else $error("pump left on");
    AST_PAGE: assert property (@(posedge clk)
        disable iff (reset) cmd_take && cmd_code == FCT_CMD_PAGE
        |=> erase_page == $past(cmd_addr[14:9]))
        else $error("page not latched");
    AST_CNT: assert property (@(posedge clk)
        disable iff (reset) busy && !tick_ff && !cmd_take |=> $stable(cnt_ff))
        else $error("count moved off tick");

    COV_BYTE: cover property (@(posedge clk) cmd_take &&
        cmd_code == FCT_CMD_BYTE);
    COV_REJ: cover property (@(posedge clk) cmd_rej);
    COV_KEEP: cover property (@(posedge clk) last && keep_pump);
    COV_DIV2: cover property (@(posedge clk) div_wr && loaded_ff);
endmodule

// >>> verification/fct_flash_command_timing_test.sv
`timescale 1ns/1ps
`define CHK(a, e) \
    begin checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, a, e); end end
module fct_flash_command_timing_test;
    import fct_pkg::*;
    // Short erase counts keep the run brief.
    localparam int PG = 20;
    localparam int MS = 40;
    logic clk = 0, reset = 1, div_wr = 0, cmd_valid = 0, err_clear = 0;
    logic [6:0] div_wdata = 7'h00, flash_clock_divider;
    fct_cmd_t cmd_code = FCT_CMD_BYTE;
    logic [14:0] cmd_addr = 15'h0000;
    logic cmd_ready, div_loaded, access_error_flag, busy, cmd_done;
    logic pump_on, ftick;
    logic [5:0] erase_page;
    int n_mismatch = 0, checks = 0, nbusy = 0, ntick = 0, exp_n, k, fdiv;
    int exp_q[$];
    int cyc[4];
    logic [7:0] rnd = 8'h1D;
    fct_flash_command_timing #(.PAGE_CYC(PG), .MASS_CYC(MS)) dut (
        .clk(clk), .reset(reset), .div_wr(div_wr), .div_wdata(div_wdata),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
        .cmd_ready(cmd_ready), .err_clear(err_clear),
        .flash_clock_divider(flash_clock_divider), .div_loaded(div_loaded),
        .access_error_flag(access_error_flag), .busy(busy),
        .cmd_done(cmd_done), .pump_on(pump_on),
        .flash_timing_clock(ftick), .erase_page(erase_page));
    // The clock toggles every half period of 5 ns.
    initial
    begin
        forever #5 clk = ~clk;
    end
    // Eight-bit shift register for repeatable pseudo-random values.
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task step;
        @(negedge clk);
    endtask
    task pulse_div(input logic [6:0] v);
        div_wdata = v;
        div_wr = 1;
        step;
        div_wr = 0;
        step;
    endtask
    // Waits for the done pulse; running out of time counts as a mismatch.
    task wait_done;
        int n;
        n = 0;
        while (cmd_done !== 1'b1 && n < 2000)
        begin
            step;
            n++;
        end
        if (n >= 2000) n_mismatch++;
    endtask
    // Issues one command and notes its expected length in timing periods.
    task run_cmd(input fct_cmd_t c, input logic [14:0] a);
        cmd_code = c;
        cmd_addr = a;
        cmd_valid = 1;
        exp_q.push_back(cyc[c]);
        step;
        cmd_valid = 0;
        wait_done;
        `CHK(pump_on, 1'b0)
        if (c == FCT_CMD_PAGE) `CHK(erase_page, a[14:9])
        step;
    endtask
    // Queues a second burst to the same row, held until it is taken.
    task burst_pair(input logic [14:0] a);
        cmd_code = FCT_CMD_BURST;
        cmd_addr = a;
        cmd_valid = 1;
        exp_q.push_back(BURST_PROG_CYC);
        step;
        cmd_addr = a + 15'h0001;
        exp_q.push_back(BURST_PROG_CYC);
        wait_done;
        `CHK(pump_on, 1'b1)
        step;
        cmd_valid = 0;
        wait_done;
        `CHK(pump_on, 1'b0)
        step;
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Watches outputs; the busy span ends at the done pulse. The prescaler
    // runs free, so the span in bus clocks is only known within one period.
    always @(negedge clk)
    begin
        if (busy === 1'b1) nbusy++;
        if (busy === 1'b1 && ftick === 1'b1) ntick++;
        if (busy === 1'b1) `CHK(pump_on, 1'b1)
        if (busy === 1'b1) `CHK(cmd_ready, 1'b0)
        if (cmd_done === 1'b1)
        begin
            exp_n = exp_q.pop_front();
            `CHK(ntick, exp_n)
            `CHK(nbusy > (exp_n - 1) * (fdiv + 1), 1'b1)
            `CHK(nbusy <= exp_n * (fdiv + 1), 1'b1)
            nbusy = 0;
            ntick = 0;
        end
    end
    // A hang is cut short well past the longest expected sequence.
    initial
    begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        test_done;
    end
    initial
    begin
        cyc = '{BYTE_PROG_CYC, BURST_PROG_CYC, PG, MS};
        repeat (4) step;
        reset = 0;
        // A command before the divider write must be refused.
        cmd_valid = 1;
        step;
        cmd_valid = 0;
        step;
        `CHK(access_error_flag, 1'b1)
        `CHK(busy, 1'b0)
        `CHK(cmd_ready, 1'b1)
        pulse_div(7'h05);
        `CHK(div_loaded, 1'b0)
        err_clear = 1;
        step;
        err_clear = 0;
        step;
        `CHK(access_error_flag, 1'b0)
        rnd = lfsr(rnd);
        fdiv = rnd[1:0];
        pulse_div(7'(fdiv));
        `CHK(div_loaded, 1'b1)
        `CHK(flash_clock_divider, 7'(fdiv))
        pulse_div(7'h7F);
        `CHK(flash_clock_divider, 7'(fdiv))
        $display("test divider done");
        for (k = 0; k < 8; k++)
        begin
            rnd = lfsr(rnd);
            run_cmd(fct_cmd_t'(k % 4), {rnd[5:0], rnd, 1'b0});
        end
        $display("test commands done");
        rnd = lfsr(rnd);
        burst_pair({rnd[5:0], rnd, 1'b0});
        $display("test burst pair done");
        test_done;
    end
endmodule
